// file: hw/cc1_pkg.sv
// Package of the dedicated-connection control block: encodings, login bits, timing.
// Assumes one 100 MHz clock and an AXI4-Lite master for the register file.
package cc1_pkg;

  // ==========================================================================
  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LOGIN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_EVENTS = 8'h0c;

  // CTRL fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_BUSY = 1;
  localparam int CTRL_ACCEPT_BIDIR = 2;
  localparam int CTRL_UNIDIR_REQ = 3;
  localparam int CTRL_RECIP_BIDIR = 4;
  localparam int CTRL_INTERMIX = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // LOGIN register: own request bits and fabric accept bits
  localparam int LOGIN_REQ_TRANSP = 29;
  localparam int LOGIN_REQ_LOCK = 28;
  localparam int LOGIN_ACC_TRANSP = 13;
  localparam int LOGIN_ACC_LOCK = 12;
  localparam int LOGIN_VALID = 0;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int ED_TOV_MS = 2;
  localparam int ED_TOV_CYCLES = (ED_TOV_MS * 1000000) / CLK_PERIOD_NS;

  // ==========================================================================
  // Frame kinds seen or produced at the frame interface
  typedef enum logic [3:0] {
    CC1_FR_DATA = 4'h0,
    CC1_FR_ACK = 4'h1,
    CC1_FR_F_BSY = 4'h2,
    CC1_FR_P_BSY = 4'h3,
    CC1_FR_F_RJT = 4'h4,
    CC1_FR_P_RJT = 4'h5
  } cc1_frame_t;

  typedef enum logic [2:0] {
    CC1_SOF_C1 = 3'h0,
    CC1_SOF_I1 = 3'h1,
    CC1_SOF_N1 = 3'h2,
    CC1_SOF_OTHER = 3'h3
  } cc1_sof_t;

  typedef enum logic [1:0] {
    CC1_EOF_N = 2'h0,
    CC1_EOF_T = 2'h1,
    CC1_EOF_DT = 2'h2
  } cc1_eof_t;

  // One frame header summary as it crosses the frame interface
  typedef struct packed {
    cc1_sof_t sof;
    cc1_frame_t kind;
    cc1_eof_t eof;
    logic first;
    logic last;
    logic unidir;
  } cc1_hdr_t;

  localparam int UNIDIR_BIT = 8;

  typedef enum logic [2:0] {
    CC1_ST_IDLE = 3'b000,
    CC1_ST_PENDING = 3'b001,
    CC1_ST_INITIATOR = 3'b010,
    CC1_ST_RECIPIENT = 3'b011,
    CC1_ST_RESET = 3'b100
  } cc1_state_t;

  typedef struct packed {
    logic transparent;
    logic lockdown;
  } cc1_stack_t;

  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

endpackage

// file: hw/cc1_mode_neg.sv
// Stacked connect-request mode negotiation from login request and accept words.
// Assumes both words are stable while the valid flag is set.
module cc1_mode_neg (
  input wire logic core_clk,
  input wire logic rst_n_sync,
  input wire logic [31:0] login_word,
  input wire logic intermix,
  output cc1_pkg::cc1_stack_t stack_ff,
  output logic stack_on_ff
);
  cc1_pkg::cc1_stack_t nxt_stack;
  logic transp_ok;
  logic lock_ok;

  assign transp_ok = login_word[cc1_pkg::LOGIN_REQ_TRANSP] &&
                     login_word[cc1_pkg::LOGIN_ACC_TRANSP] && intermix;
  assign lock_ok = login_word[cc1_pkg::LOGIN_REQ_LOCK] &&
                   login_word[cc1_pkg::LOGIN_ACC_LOCK] && intermix;

  always_comb begin
    nxt_stack.transparent = 1'b0;
    nxt_stack.lockdown = 1'b0;
    // both may be requested; both requested and accepted by the fabric is treated as neither
    if (login_word[cc1_pkg::LOGIN_VALID] && !(transp_ok && lock_ok)) begin
      nxt_stack.transparent = transp_ok;
      nxt_stack.lockdown = lock_ok;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      stack_ff <= '0;
      stack_on_ff <= 1'b0;
    end else begin
      stack_ff <= nxt_stack;
      // stacking only with intermix and login support
      stack_on_ff <= nxt_stack.transparent | nxt_stack.lockdown;
    end
  end
endmodule

// file: hw/cc1_timer.sv
// Response timer for an outstanding connect-request.
// Assumes start and stop come from logic on the same clock.
module cc1_timer #(
  parameter int unsigned LIMIT = cc1_pkg::ED_TOV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n_sync,
  input wire logic start,
  input wire logic stop,
  output logic expired_ff
);
  logic [31:0] count_ff;
  logic run_ff;

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      count_ff <= 32'h0000_0000;
      run_ff <= 1'b0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (stop) begin
        run_ff <= 1'b0;
      end else if (start) begin
        // Restart on every request not met by a stop in the same cycle, so the newest one is timed
        run_ff <= 1'b1;
        count_ff <= 32'h0000_0000;
      end else if (run_ff) begin
        if (count_ff == LIMIT - 1) begin
          run_ff <= 1'b0;
          expired_ff <= 1'b1;
        end else begin
          count_ff <= count_ff + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// file: hw/cc1_conn_ctrl.sv
// Dedicated-connection control: connect-request handling, direction, recovery.
// Assumes a framer upstream that presents one header per strobe, same clock,
// and an AXI4-Lite master for configuration and status.

module cc1_conn_ctrl #(
  parameter int unsigned ED_TOV_LIMIT = cc1_pkg::ED_TOV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Frames received from the link
  input wire logic rx_valid,
  input wire cc1_pkg::cc1_hdr_t rx_hdr,
  // Request from the sequence engine to send a connect-request
  input wire logic conn_req,
  // Frames this block asks the transmitter to send
  output logic tx_valid_ff,
  output cc1_pkg::cc1_hdr_t tx_hdr_ff,
  output cc1_pkg::cc1_state_t state_ff,
  output logic may_send_data_ff,
  output logic may_recv_data_ff,
  output logic link_reset_ff
);
  // ==========================================================================
  // Reset synchroniser
  logic rst_meta_ff;
  logic rst_n_sync;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_sync <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Register file
  logic [31:0] ctrl_ff;
  logic [31:0] login_ff;
  logic [7:0] events_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic do_write;
  logic evt_clear;
  logic [7:0] evt_clear_mask;
  cc1_pkg::cc1_stack_t stack;
  logic stack_on;
  logic unidir_ff;
  logic recip_asked_ff;
  logic nxt_unidir;

  function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cc1_pkg::AXI_OKAY;
    end else begin
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_ff == cc1_pkg::ADDR_CTRL ||
                        aw_addr_ff == cc1_pkg::ADDR_LOGIN ||
                        aw_addr_ff == cc1_pkg::ADDR_EVENTS) ?
                       cc1_pkg::AXI_OKAY : cc1_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ctrl_ff <= cc1_pkg::CTRL_RESET;
      login_ff <= 32'h0000_0000;
    end else if (do_write) begin
      if (aw_addr_ff == cc1_pkg::ADDR_CTRL) begin
        ctrl_ff <= apply_strb(ctrl_ff, w_data_ff, w_strb_ff);
      end
      if (aw_addr_ff == cc1_pkg::ADDR_LOGIN) begin
        login_ff <= apply_strb(login_ff, w_data_ff, w_strb_ff);
      end
    end
  end

  assign evt_clear = do_write && aw_addr_ff == cc1_pkg::ADDR_EVENTS && w_strb_ff[0];
  assign evt_clear_mask = evt_clear ? w_data_ff[7:0] : 8'h00;

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cc1_pkg::AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= cc1_pkg::AXI_OKAY;
        case (s_axi_araddr)
          cc1_pkg::ADDR_CTRL: s_axi_rdata <= ctrl_ff;
          cc1_pkg::ADDR_LOGIN: s_axi_rdata <= login_ff;
          cc1_pkg::ADDR_STATUS: s_axi_rdata <= {24'h000000, stack_on, stack.lockdown,
                                                stack.transparent, unidir_ff,
                                                1'b0, state_ff};
          cc1_pkg::ADDR_EVENTS: s_axi_rdata <= {24'h000000, events_ff};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= cc1_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Mode negotiation and response timer
  logic tmo;
  logic req_fire;
  logic resp_ok;

  cc1_mode_neg u_mode (
    .core_clk(core_clk),
    .rst_n_sync(rst_n_sync),
    .login_word(login_ff),
    .intermix(ctrl_ff[cc1_pkg::CTRL_INTERMIX]),
    .stack_ff(stack),
    .stack_on_ff(stack_on)
  );

  cc1_timer #(.LIMIT(ED_TOV_LIMIT)) u_timer (
    .core_clk(core_clk),
    .rst_n_sync(rst_n_sync),
    .start(req_fire),
    .stop(resp_ok),
    .expired_ff(tmo)
  );

  // ==========================================================================
  // Frame decode
  logic rx_creq;
  logic rx_meaningful;
  logic rx_foreign_n1;
  assign req_fire = conn_req && ctrl_ff[cc1_pkg::CTRL_ENABLE] && !rx_creq &&
                    (state_ff == cc1_pkg::CC1_ST_IDLE || stack_on);
  assign rx_creq = rx_valid && rx_hdr.sof == cc1_pkg::CC1_SOF_C1 &&
                   rx_hdr.kind == cc1_pkg::CC1_FR_DATA;
  // ACK or fabric busy ends the wait
  assign resp_ok = rx_valid && rx_hdr.sof == cc1_pkg::CC1_SOF_N1 &&
                   (rx_hdr.kind == cc1_pkg::CC1_FR_ACK ||
                    rx_hdr.kind == cc1_pkg::CC1_FR_F_BSY);
  // only first and last data frames count
  assign rx_meaningful = rx_valid && rx_hdr.kind == cc1_pkg::CC1_FR_DATA &&
                         (rx_hdr.first || rx_hdr.last);
  assign rx_foreign_n1 = rx_valid && rx_hdr.sof == cc1_pkg::CC1_SOF_N1 &&
                         rx_hdr.kind == cc1_pkg::CC1_FR_ACK;

  // ==========================================================================
  // Connection state
  cc1_pkg::cc1_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cc1_pkg::CC1_ST_IDLE: begin
        if (rx_creq && !ctrl_ff[cc1_pkg::CTRL_BUSY]) begin
          nxt_state = cc1_pkg::CC1_ST_RECIPIENT;
        end else if (req_fire) begin
          nxt_state = cc1_pkg::CC1_ST_PENDING;
        end
      end
      cc1_pkg::CC1_ST_PENDING: begin
        if (tmo) begin
          nxt_state = cc1_pkg::CC1_ST_RESET;
        end else if (resp_ok && rx_hdr.kind == cc1_pkg::CC1_FR_ACK) begin
          nxt_state = cc1_pkg::CC1_ST_INITIATOR;
        end else if (rx_valid && rx_hdr.sof == cc1_pkg::CC1_SOF_N1) begin
          nxt_state = cc1_pkg::CC1_ST_IDLE;
        end else if (rx_creq) begin
          nxt_state = cc1_pkg::CC1_ST_RECIPIENT;
        end
      end
      cc1_pkg::CC1_ST_INITIATOR, cc1_pkg::CC1_ST_RECIPIENT: begin
        // unexpected connect or reply means state is uncertain
        if (tmo || rx_creq || (rx_foreign_n1 && !stack_on)) begin
          nxt_state = cc1_pkg::CC1_ST_RESET;
        end else if (rx_valid && rx_hdr.eof == cc1_pkg::CC1_EOF_DT) begin
          nxt_state = cc1_pkg::CC1_ST_IDLE;
        end
      end
      cc1_pkg::CC1_ST_RESET: nxt_state = cc1_pkg::CC1_ST_IDLE;
      default: nxt_state = cc1_pkg::CC1_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_ff <= cc1_pkg::CC1_ST_IDLE;
      link_reset_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      link_reset_ff <= nxt_state == cc1_pkg::CC1_ST_RESET;
    end
  end

  // ==========================================================================
  // Direction tracking
  always_comb begin
    nxt_unidir = unidir_ff;
    if (nxt_state == cc1_pkg::CC1_ST_IDLE) begin
      nxt_unidir = 1'b0;
    end else if (rx_creq && nxt_state == cc1_pkg::CC1_ST_RECIPIENT) begin
      // transparent leaves return path open unless the bit says otherwise
      nxt_unidir = rx_hdr.unidir;
    end else if (req_fire && state_ff == cc1_pkg::CC1_ST_IDLE) begin
      nxt_unidir = stack.lockdown || ctrl_ff[cc1_pkg::CTRL_UNIDIR_REQ];
    end else if (state_ff == cc1_pkg::CC1_ST_RECIPIENT && rx_meaningful &&
                 !rx_hdr.unidir) begin
      // initiator clears the bit, bidirectional for good
      nxt_unidir = 1'b0;
    end else if (state_ff == cc1_pkg::CC1_ST_INITIATOR && rx_valid &&
                 rx_hdr.kind == cc1_pkg::CC1_FR_ACK && !rx_hdr.unidir) begin
      // initiator honours the ask only if software allows
      if (ctrl_ff[cc1_pkg::CTRL_ACCEPT_BIDIR]) begin
        nxt_unidir = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      unidir_ff <= 1'b0;
      recip_asked_ff <= 1'b0;
    end else begin
      unidir_ff <= nxt_unidir;
      recip_asked_ff <= nxt_state != cc1_pkg::CC1_ST_IDLE && (recip_asked_ff ||
                        (state_ff == cc1_pkg::CC1_ST_RECIPIENT && unidir_ff &&
                         ctrl_ff[cc1_pkg::CTRL_RECIP_BIDIR]));
    end
  end

  // bidirectional allows both; unidirectional splits roles
  // bidirectional recipient may start sequences
  // Next direction used so a new connection never grants a stale permission
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      may_send_data_ff <= 1'b0;
      may_recv_data_ff <= 1'b0;
    end else begin
      may_send_data_ff <= (nxt_state == cc1_pkg::CC1_ST_INITIATOR) ||
                          (nxt_state == cc1_pkg::CC1_ST_RECIPIENT && !nxt_unidir);
      may_recv_data_ff <= (nxt_state == cc1_pkg::CC1_ST_RECIPIENT) ||
                          (nxt_state == cc1_pkg::CC1_ST_INITIATOR && !nxt_unidir);
    end
  end

  // ==========================================================================
  // Transmit requests
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tx_valid_ff <= 1'b0;
      tx_hdr_ff <= '0;
    end else begin
      tx_valid_ff <= 1'b0;
      if (rx_creq && state_ff == cc1_pkg::CC1_ST_IDLE &&
          ctrl_ff[cc1_pkg::CTRL_BUSY]) begin
        tx_valid_ff <= 1'b1;
        tx_hdr_ff <= '{sof: cc1_pkg::CC1_SOF_N1, kind: cc1_pkg::CC1_FR_P_BSY,
                       eof: cc1_pkg::CC1_EOF_DT, first: 1'b1, last: 1'b1, unidir: 1'b0};
      end else if (rx_creq && nxt_state == cc1_pkg::CC1_ST_RECIPIENT) begin
        tx_valid_ff <= 1'b1;
        tx_hdr_ff <= '{sof: cc1_pkg::CC1_SOF_N1, kind: cc1_pkg::CC1_FR_ACK,
                       eof: cc1_pkg::CC1_EOF_T, first: 1'b1, last: 1'b1, unidir: 1'b1};
      end else if (req_fire) begin
        tx_valid_ff <= 1'b1;
        tx_hdr_ff <= '{sof: cc1_pkg::CC1_SOF_C1, kind: cc1_pkg::CC1_FR_DATA,
                       eof: cc1_pkg::CC1_EOF_N, first: 1'b1, last: 1'b0,
                       unidir: stack.lockdown || ctrl_ff[cc1_pkg::CTRL_UNIDIR_REQ]};
      end else if (state_ff == cc1_pkg::CC1_ST_RECIPIENT && rx_valid &&
                   rx_hdr.kind == cc1_pkg::CC1_FR_DATA) begin
        // ACK carries the bidirectional ask, sticky
        tx_valid_ff <= 1'b1;
        tx_hdr_ff <= '{sof: cc1_pkg::CC1_SOF_I1, kind: cc1_pkg::CC1_FR_ACK,
                       eof: cc1_pkg::CC1_EOF_T, first: 1'b1, last: 1'b1,
                       unidir: !(recip_asked_ff || ctrl_ff[cc1_pkg::CTRL_RECIP_BIDIR])};
      end
    end
  end

  // ==========================================================================
  // Sticky events, set wins over clear
  logic [7:0] evt_set;
  assign evt_set = {4'h0, link_reset_ff, tmo, resp_ok, rx_creq};
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      events_ff <= 8'h00;
    end else begin
      events_ff <= (events_ff & ~evt_clear_mask) | evt_set;
    end
  end
endmodule

// file: testbench/cc1_conn_ctrl_props.sv
// Port checker for the dedicated-connection control block.
// Assumes it is bound into every cc1_conn_ctrl instance.
module cc1_conn_ctrl_props #(
  parameter int unsigned ED_TOV_LIMIT = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire cc1_pkg::cc1_hdr_t rx_hdr,
  input wire logic tx_valid_ff,
  input wire cc1_pkg::cc1_hdr_t tx_hdr_ff,
  input wire cc1_pkg::cc1_state_t state_ff,
  input wire logic may_send_data_ff,
  input wire logic may_recv_data_ff,
  input wire logic link_reset_ff
);
  logic [31:0] pend_cnt_ff;
  wire logic pend = state_ff == cc1_pkg::CC1_ST_PENDING;
  // Counter, as the timeout is far beyond a repetition count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_cnt_ff <= 32'h0;
    end else begin
      pend_cnt_ff <= pend ? pend_cnt_ff + 32'h1 : 32'h0;
    end
  end
  // ====================
  // Properties
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  property p_req_out;
    pend && $past(state_ff) == cc1_pkg::CC1_ST_IDLE
      |-> tx_valid_ff && tx_hdr_ff.sof == cc1_pkg::CC1_SOF_C1;
  endproperty
  a_req_out: assert property (p_req_out)
    else $error("request left without a C1 frame");
  property p_ack;
    pend && rx_valid && rx_hdr.kind == cc1_pkg::CC1_FR_ACK && rx_hdr.sof == cc1_pkg::CC1_SOF_N1
      |=> state_ff == cc1_pkg::CC1_ST_INITIATOR;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ACK did not make initiator");
  property p_tmo;
    pend_cnt_ff <= ED_TOV_LIMIT + 2;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("pending past the timeout");
  property p_reset_one;
    state_ff == cc1_pkg::CC1_ST_RESET |=> state_ff != cc1_pkg::CC1_ST_RESET;
  endproperty
  a_reset_one: assert property (p_reset_one)
    else $error("recovery state held");
  property p_bsy_end;
    tx_valid_ff && tx_hdr_ff.kind == cc1_pkg::CC1_FR_P_BSY |-> tx_hdr_ff.eof == cc1_pkg::CC1_EOF_DT;
  endproperty
  a_bsy_end: assert property (p_bsy_end)
    else $error("port busy without disconnect end");
  property p_dest;
    state_ff == cc1_pkg::CC1_ST_IDLE && rx_valid && rx_hdr.sof == cc1_pkg::CC1_SOF_C1
      && rx_hdr.kind == cc1_pkg::CC1_FR_DATA
      |=> tx_valid_ff && tx_hdr_ff.sof == cc1_pkg::CC1_SOF_N1;
  endproperty
  a_dest: assert property (p_dest)
    else $error("connect-request not answered");
  property p_recip_quiet;
    state_ff == cc1_pkg::CC1_ST_RECIPIENT && $rose(may_send_data_ff)
      |-> $past(rx_valid) && !$past(rx_hdr.unidir);
  endproperty
  a_recip_quiet: assert property (p_recip_quiet)
    else $error("unidirectional recipient sent data");
  property p_init_send;
    $stable(state_ff) && state_ff == cc1_pkg::CC1_ST_INITIATOR |-> may_send_data_ff;
  endproperty
  a_init_send: assert property (p_init_send)
    else $error("initiator may not send");
  property p_recip_recv;
    $stable(state_ff) && state_ff == cc1_pkg::CC1_ST_RECIPIENT |-> may_recv_data_ff;
  endproperty
  a_recip_recv: assert property (p_recip_recv)
    else $error("recipient may not receive");
  c_init: cover property (state_ff == cc1_pkg::CC1_ST_INITIATOR);
  c_lr: cover property (link_reset_ff);
  c_bsy: cover property (tx_valid_ff && tx_hdr_ff.kind == cc1_pkg::CC1_FR_P_BSY);
endmodule

bind cc1_conn_ctrl cc1_conn_ctrl_props #(.ED_TOV_LIMIT(ED_TOV_LIMIT)) u_props (
  .core_clk, .rst_n, .rx_valid, .rx_hdr, .tx_valid_ff, .tx_hdr_ff, .state_ff,
  .may_send_data_ff, .may_recv_data_ff, .link_reset_ff
);

// file: testbench/cc1_fabric_model.sv
// Far-side model: answers connect-requests, injects frames on demand.
// Mode 0 answers at once, 1 stays silent, 2 answers late.
module cc1_fabric_model (
  input wire logic core_clk,
  input wire logic [1:0] mode,
  input wire logic inj,
  input wire cc1_pkg::cc1_hdr_t inj_hdr,
  input wire logic tx_valid_ff,
  input wire cc1_pkg::cc1_hdr_t tx_hdr_ff,
  output logic rx_valid = 1'b0,
  output cc1_pkg::cc1_hdr_t rx_hdr = '0
);
  logic [2:0] dly_ff = 3'h0;
  always_ff @(posedge core_clk) begin
    rx_valid <= inj || dly_ff == 3'h1;
    rx_hdr <= inj ? inj_hdr : ~rx_hdr;
    if (!inj && dly_ff == 3'h1) begin
      rx_hdr.sof <= cc1_pkg::CC1_SOF_N1;
      rx_hdr.kind <= cc1_pkg::CC1_FR_ACK;
      rx_hdr.eof <= cc1_pkg::CC1_EOF_T;
    end
    if (tx_valid_ff && tx_hdr_ff.sof == cc1_pkg::CC1_SOF_C1 && mode != 2'h1) begin
      dly_ff <= mode[1] ? 3'h6 : 3'h1;
    end else if (dly_ff != 3'h0) begin
      dly_ff <= dly_ff - 3'h1;
    end
  end
endmodule

// file: testbench/tb_cc1_conn_ctrl.sv
// Self-checking bench for the dedicated-connection control block.
// Assumes the far-side model on the frame ports.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_cc1_conn_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned LIM = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic conn_req = 1'b0;
  logic inj = 1'b0;
  logic [1:0] mode = 2'h0;
  cc1_pkg::cc1_hdr_t inj_hdr = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic rx_valid, tx_valid_ff, may_send_data_ff, may_recv_data_ff, link_reset_ff;
  cc1_pkg::cc1_hdr_t rx_hdr, tx_hdr_ff, h;
  cc1_pkg::cc1_state_t state_ff;
  int cmp_count = 0;
  int n_mismatch = 0;
  // Row: intermix, own transp/lock, accept transp/lock, expected on/lock/transp
  logic [7:0] rows [7] = '{8'hf5, 8'hee, 8'hf8, 8'hc8, 8'h70, 8'h90, 8'hae};

  cc1_conn_ctrl #(.ED_TOV_LIMIT(LIM)) uut (
    .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_valid, .rx_hdr, .conn_req, .tx_valid_ff, .tx_hdr_ff, .state_ff,
    .may_send_data_ff, .may_recv_data_ff, .link_reset_ff
  );
  cc1_fabric_model fab (
    .core_clk, .mode, .inj, .inj_hdr, .tx_valid_ff, .tx_hdr_ff, .rx_valid, .rx_hdr
  );
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ====================
  // Tasks
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tmo(input bit bad);
    if (bad) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
    tmo(n >= 50);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    tmo(n >= 50);
  endtask
  function automatic bit hit(input int what);
    case (what)
      0: return tx_valid_ff === 1'b1;
      1: return link_reset_ff === 1'b1;
      2: return state_ff === cc1_pkg::CC1_ST_INITIATOR;
      3: return state_ff === cc1_pkg::CC1_ST_RECIPIENT;
      default: return may_send_data_ff === 1'b1;
    endcase
  endfunction
  task automatic wt(input int what, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!hit(what) && n < lim);
    h = tx_hdr_ff;
    tmo(!hit(what));
  endtask
  task automatic req();
    conn_req <= 1'b1;
    @(posedge core_clk);
    conn_req <= 1'b0;
  endtask
  task automatic send(input cc1_pkg::cc1_sof_t s, input logic [2:0] flu);
    inj_hdr <= '{s, cc1_pkg::CC1_FR_DATA, cc1_pkg::CC1_EOF_N, flu[2], flu[1], flu[0]};
    inj <= 1'b1;
    @(posedge core_clk);
    inj <= 1'b0;
    @(posedge core_clk);
  endtask
  // ====================
  // Sequence
  initial begin
    do_reset();
    wr(cc1_pkg::ADDR_STATUS, 32'hff);
    `CHK(r, cc1_pkg::AXI_SLVERR)
    rd(8'h10);
    `CHK(r, cc1_pkg::AXI_SLVERR)
    foreach (rows[i]) begin
      wr(cc1_pkg::ADDR_CTRL, {26'h0, rows[i][7], 5'h01});
      wr(cc1_pkg::ADDR_LOGIN, {2'h0, rows[i][6:5], 14'h0, rows[i][4:3], 11'h0, 1'b1});
      rd(cc1_pkg::ADDR_STATUS);
      `CHK(d[7:5], rows[i][2:0])
    end
    req();
    wt(0, 10);
    `CHK(h.unidir, 1'b1)
    wt(2, 10);
    req();
    wt(0, 10);
    `CHK(h.sof, cc1_pkg::CC1_SOF_C1)
    do_reset();
    mode <= 2'h2;
    req();
    wt(2, 20);
    `CHK(state_ff, cc1_pkg::CC1_ST_INITIATOR)
    do_reset();
    mode <= 2'h1;
    req();
    wt(1, LIM + 10);
    `CHK(link_reset_ff, 1'b1)
    rd(cc1_pkg::ADDR_EVENTS);
    `CHK(d[7:0], 8'h0c)
    wr(cc1_pkg::ADDR_EVENTS, 32'hff);
    rd(cc1_pkg::ADDR_EVENTS);
    `CHK(d[7:0], 8'h00)
    do_reset();
    wr(cc1_pkg::ADDR_CTRL, 32'h3);
    send(cc1_pkg::CC1_SOF_C1, 3'b101);
    wt(0, 10);
    `CHK(h.eof, cc1_pkg::CC1_EOF_DT)
    wr(cc1_pkg::ADDR_CTRL, 32'h1);
    send(cc1_pkg::CC1_SOF_C1, 3'b101);
    wt(0, 10);
    `CHK(h.kind, cc1_pkg::CC1_FR_ACK)
    wt(3, 10);
    `CHK(may_send_data_ff, 1'b0)
    send(cc1_pkg::CC1_SOF_N1, 3'b000);
    `CHK(may_send_data_ff, 1'b0)
    send(cc1_pkg::CC1_SOF_I1, 3'b110);
    wt(4, 10);
    `CHK(may_recv_data_ff, 1'b1)
    `CHK(may_send_data_ff, 1'b1)
    final_report();
  end
endmodule
